// file: hdl/fmwa_top.sv
`default_nettype none
// window-addressed frame memory access engine
module fmwa_top
  import fmwa_pkg::*;
#(
  parameter int COLS  = 240,
  parameter int PAGES = 432
) (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                cmd_valid,
  input  wire logic [7:0]          cmd_code,
  input  wire logic                data_valid,
  input  wire logic [FMWA_PW-1:0]  data_in,
  input  wire logic                read_req,
  input  wire logic                row_column_exchange,
  input  wire logic                line_order_select,
  output logic                     read_valid,
  output logic [FMWA_RW-1:0]       read_data,
  output logic [FMWA_AW-1:0]       window_first_column,
  output logic [FMWA_AW-1:0]       window_last_column,
  output logic [FMWA_AW-1:0]       window_first_page,
  output logic [FMWA_AW-1:0]       window_last_page,
  output logic [FMWA_AW-1:0]       partial_first_row,
  output logic [FMWA_AW-1:0]       partial_last_row,
  output logic                     partial_wraps,
  output logic                     partial_from_bottom,
  output logic                     transfer_busy
);
  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  // counters are FMWA_AW bits wide, so a larger store could never be reached
  if (COLS < 1 || COLS > (1 << FMWA_AW)) begin : g_cols_check
    $error("column count out of range");
  end
  if (PAGES < 1 || PAGES > (1 << FMWA_AW)) begin : g_pages_check
    $error("page count out of range");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    fmwa_state_e        st;      // command engine phase
    logic [7:0]         cmd;     // command that owns the parameter bytes
    logic [1:0]         pidx;    // parameter byte index
    logic [FMWA_AW-1:0] p_hi;    // high bit of the value being assembled
    logic [FMWA_AW-1:0] p_lo;    // first value of a parameter pair
    logic [FMWA_AW-1:0] fc;      // window first column
    logic [FMWA_AW-1:0] lc;      // window last column
    logic [FMWA_AW-1:0] fp;      // window first page
    logic [FMWA_AW-1:0] lp;      // window last page
    logic [FMWA_AW-1:0] fr;      // partial first row
    logic [FMWA_AW-1:0] lr;      // partial last row
    logic [FMWA_AW-1:0] col;     // live column counter
    logic [FMWA_AW-1:0] page;    // live page counter
    logic               rd_pend; // memory word on its way back
    logic               rvalid;
    logic [FMWA_RW-1:0] rdata;
  } fmwa_state_s;

  // registered state and its next value
  fmwa_state_s s_q, s_d;
  // memory port towards the frame store
  fmwa_mem_if  mem ();

  // the store has no reset input, so pixel data outlives every reset
  fmwa_frame_store #(.COLS(COLS), .PAGES(PAGES)) u_store (
    .sys_clk (sys_clk),
    .mem     (mem)
  );

  // counters sitting on the window edge
  logic               col_end, page_end;
  // nine-bit value made of the held high bit and the low byte now on the bus
  logic [FMWA_AW-1:0] pval;
  // a pixel stored or a read started in this cycle; a command byte always wins
  logic               wr_fire, rd_fire;

  // window edge detection shared by both walk directions
  assign col_end  = (s_q.col == s_q.lc);
  assign page_end = (s_q.page == s_q.lp);
  assign pval     = {s_q.p_hi[0], data_in[7:0]};
  assign wr_fire  = (s_q.st == FMWA_WR) && data_valid && !cmd_valid;
  assign rd_fire  = (s_q.st == FMWA_RD) && read_req && !cmd_valid && !s_q.rd_pend;

  // memory port driven from the live counters
  assign mem.we    = wr_fire;
  assign mem.col   = s_q.col;
  assign mem.page  = s_q.page;
  assign mem.wdata = data_in;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;
    if (cmd_valid) begin
      // a new command ends any transfer in progress
      s_d.cmd     = cmd_code;
      s_d.pidx    = '0;
      s_d.rd_pend = 1'b0;
      s_d.col     = s_q.fc;
      s_d.page    = s_q.fp;
      // parameter commands collect four bytes, unknown codes just go idle
      case (cmd_code)
        FMWA_CMD_COL, FMWA_CMD_PAGE, FMWA_CMD_PART: s_d.st = FMWA_PARAM;
        FMWA_CMD_WRITE: s_d.st = FMWA_WR;
        FMWA_CMD_READ:  s_d.st = FMWA_RD_DUMMY;
        default:        s_d.st = FMWA_IDLE;
      endcase
    end else begin
      case (s_q.st)
        FMWA_PARAM: begin
          if (data_valid) begin
            s_d.pidx = s_q.pidx + 2'h1;
            if (s_q.pidx[0] == 1'b0) begin
              s_d.p_hi = {{(FMWA_AW-1){1'b0}}, data_in[0]};
            end else if (s_q.pidx == 2'h1) begin
              s_d.p_lo = pval;
            end
            // the fourth byte commits the pair; bounds are judged only then
            if (s_q.pidx == FMWA_LAST_PARAM) begin
              s_d.st = FMWA_IDLE;
              case (s_q.cmd)
                FMWA_CMD_COL: begin
                  // reversed or oversized bounds leave the window as it was
                  if (s_q.p_lo <= pval && int'(pval) < COLS) begin
                    s_d.fc = s_q.p_lo;
                    s_d.lc = pval;
                  end
                end
                FMWA_CMD_PAGE: begin
                  if (s_q.p_lo <= pval && int'(pval) < PAGES) begin
                    s_d.fp = s_q.p_lo;
                    s_d.lp = pval;
                  end
                end
                FMWA_CMD_PART: begin
                  s_d.fr = s_q.p_lo;
                  s_d.lr = pval;
                end
                default: s_d.st = FMWA_IDLE;
              endcase
            end
          end
        end
        FMWA_WR, FMWA_RD: begin
          if (wr_fire || rd_fire) begin
            // walk the window; past its capacity the transfer goes dead
            if (!row_column_exchange) begin
              if (!col_end) s_d.col = s_q.col + 9'h001;
              else if (!page_end) begin
                s_d.col  = s_q.fc;
                s_d.page = s_q.page + 9'h001;
              end else s_d.st = FMWA_DONE;
            end else begin
              if (!page_end) s_d.page = s_q.page + 9'h001;
              else if (!col_end) begin
                s_d.page = s_q.fp;
                s_d.col  = s_q.col + 9'h001;
              end else s_d.st = FMWA_DONE;
            end
          end
          if (rd_fire) s_d.rd_pend = 1'b1;
        end
        FMWA_RD_DUMMY: begin
          if (read_req) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = '0;
            s_d.st     = FMWA_RD;
          end
        end
        FMWA_DONE, FMWA_IDLE: s_d.st = s_q.st;
        default: s_d.st = FMWA_IDLE;
      endcase
      // registered memory word returns one cycle after the address
      if (s_q.rd_pend) begin
        s_d.rd_pend = 1'b0;
        s_d.rvalid  = 1'b1;
        // 6 bits per colour widened to 8, whatever the pixel format
        s_d.rdata = {mem.rdata[17:12], 2'b00, mem.rdata[11:6], 2'b00,
                     mem.rdata[5:0], 2'b00};
      end
    end
  end

  // ****************************************************************
  // state register; frame memory itself is left alone here
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    // only constants here: window, partial rows and engine go back to defaults
    if (rst) begin
      s_q      <= '0;
      s_q.st   <= FMWA_IDLE;
      s_q.lc   <= FMWA_COL_RST_LAST;
      s_q.lp   <= FMWA_PAGE_RST_LAST;
      s_q.fr   <= FMWA_PART_RST_FIRST;
      s_q.lr   <= FMWA_PART_RST_LAST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // read word and its one-cycle strobe, both straight from flip-flops
  assign read_valid          = s_q.rvalid;
  assign read_data           = s_q.rdata;
  // current window bounds
  assign window_first_column = s_q.fc;
  assign window_last_column  = s_q.lc;
  assign window_first_page   = s_q.fp;
  assign window_last_page    = s_q.lp;
  // partial area rows, the wrap flag derived from them and the line order flag taken from its input
  assign partial_first_row   = s_q.fr;
  assign partial_last_row    = s_q.lr;
  assign partial_wraps       = (s_q.lr < s_q.fr);
  assign partial_from_bottom = line_order_select;
  // busy while a pixel transfer owns the data bus; drops once the window is full
  assign transfer_busy       = (s_q.st == FMWA_WR) || (s_q.st == FMWA_RD)
                               || (s_q.st == FMWA_RD_DUMMY);
endmodule
`default_nettype wire

// file: hdl/fmwa_pkg.sv
`default_nettype none
package fmwa_pkg;
  // ****************************************************************
  // command codes and geometry
  // ****************************************************************
  localparam logic [7:0] FMWA_CMD_COL   = 8'h2A;
  localparam logic [7:0] FMWA_CMD_PAGE  = 8'h2B;
  localparam logic [7:0] FMWA_CMD_WRITE = 8'h2C;
  localparam logic [7:0] FMWA_CMD_READ  = 8'h2E;
  localparam logic [7:0] FMWA_CMD_PART  = 8'h30;
  localparam int         FMWA_AW        = 9;
  localparam int         FMWA_PW        = 18;
  localparam int         FMWA_RW        = 24;
  localparam logic [8:0] FMWA_COL_RST_LAST  = 9'h0EF;
  localparam logic [8:0] FMWA_PAGE_RST_LAST = 9'h1AF;
  localparam logic [8:0] FMWA_PART_RST_FIRST = 9'h000;
  localparam logic [8:0] FMWA_PART_RST_LAST  = 9'h1AF;
  localparam logic [8:0] FMWA_LAST_LINE      = 9'h1DF;
  localparam logic [1:0] FMWA_LAST_PARAM     = 2'h3;
  typedef enum logic [2:0] {FMWA_IDLE, FMWA_PARAM, FMWA_WR, FMWA_RD_DUMMY, FMWA_RD,
                            FMWA_DONE} fmwa_state_e;
endpackage
`default_nettype wire

// file: hdl/fmwa_mem_if.sv
`default_nettype none
// memory port between the command engine and the frame store
interface fmwa_mem_if;
  import fmwa_pkg::*;
  logic                we;
  logic [FMWA_AW-1:0]  col;
  logic [FMWA_AW-1:0]  page;
  logic [FMWA_PW-1:0]  wdata;
  logic [FMWA_PW-1:0]  rdata;
  modport engine (output we, output col, output page, output wdata, input rdata);
  modport store  (input we, input col, input page, input wdata, output rdata);
endinterface
`default_nettype wire

// file: hdl/fmwa_frame_store.sv
`default_nettype none
// frame memory: synchronous write, registered read
module fmwa_frame_store
  import fmwa_pkg::*;
#(
  parameter int COLS  = 240,
  parameter int PAGES = 432
) (
  input wire logic    sys_clk,
  fmwa_mem_if.store   mem
);
  // addresses are FMWA_AW bits wide, so a larger array could never be reached
  if (COLS < 1 || COLS > (1 << FMWA_AW)) begin : g_cols_check
    $error("column count out of range");
  end
  if (PAGES < 1 || PAGES > (1 << FMWA_AW)) begin : g_pages_check
    $error("page count out of range");
  end
  logic [FMWA_PW-1:0] ram [COLS*PAGES];
  logic [FMWA_PW-1:0] rdata_q;
  // no reset on purpose: contents survive every reset
  always_ff @(posedge sys_clk) begin
    if (mem.we && int'(mem.col) < COLS && int'(mem.page) < PAGES) begin
      ram[int'(mem.page) * COLS + int'(mem.col)] <= mem.wdata;
    end
    if (int'(mem.col) < COLS && int'(mem.page) < PAGES) begin
      rdata_q <= ram[int'(mem.page) * COLS + int'(mem.col)];
    end else begin
      rdata_q <= '0;
    end
  end
  assign mem.rdata = rdata_q;
endmodule
`default_nettype wire

// file: testbench/fmwa_properties.sv
`default_nettype none
module fmwa_properties
  import fmwa_pkg::*;
(
  input wire logic               sys_clk,
  input wire logic               rst,
  input wire logic               cmd_valid,
  input wire logic [7:0]         cmd_code,
  input wire logic               data_valid,
  input wire logic               read_req,
  input wire logic               line_order_select,
  input wire logic               read_valid,
  input wire logic [FMWA_RW-1:0] read_data,
  input wire logic [FMWA_AW-1:0] window_first_column,
  input wire logic [FMWA_AW-1:0] window_first_page,
  input wire logic [FMWA_AW-1:0] partial_first_row,
  input wire logic [FMWA_AW-1:0] partial_last_row,
  input wire logic               partial_wraps,
  input wire logic               partial_from_bottom
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // port relations
  // ****************************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // read command followed at once by the first host strobe
  sequence rd_start;
    (cmd_valid && cmd_code == FMWA_CMD_READ) ##1 (read_req && !cmd_valid);
  endsequence
  dummy_word_a: assert property (rd_start |=> read_valid && read_data == 24'h000000)
    else $error("dummy word wrong");
  read_format_a: assert property (read_valid |-> read_data[17:16] == 2'h0
    && read_data[9:8] == 2'h0 && read_data[1:0] == 2'h0) else $error("read format wrong");
  read_cause_a: assert property (read_valid |-> $past(read_req) || $past(read_req, 2))
    else $error("read word without strobe");
  valid_pulse_a: assert property (read_valid |=> !read_valid)
    else $error("read valid too long");
  part_reset_a: assert property ($fell(rst) |-> partial_first_row == FMWA_PART_RST_FIRST
    && partial_last_row == FMWA_PART_RST_LAST) else $error("partial reset value");
  part_wrap_a: assert property (partial_wraps == (partial_last_row < partial_first_row))
    else $error("wrap flag wrong");
  line_order_a: assert property (partial_from_bottom == line_order_select)
    else $error("line order wrong");
  col_hold_a: assert property ($changed(window_first_column) |-> $past(data_valid))
    else $error("column moved without data");
  page_hold_a: assert property ($changed(window_first_page) |-> $past(data_valid))
    else $error("page moved without data");
  part_hold_a: assert property ($changed(partial_last_row) |-> $past(data_valid))
    else $error("partial row moved without data");
endmodule
bind fmwa_top fmwa_properties fmwa_properties_inst (
  .sys_clk             (sys_clk),
  .rst                 (rst),
  .cmd_valid           (cmd_valid),
  .cmd_code            (cmd_code),
  .data_valid          (data_valid),
  .read_req            (read_req),
  .line_order_select   (line_order_select),
  .read_valid          (read_valid),
  .read_data           (read_data),
  .window_first_column (window_first_column),
  .window_first_page   (window_first_page),
  .partial_first_row   (partial_first_row),
  .partial_last_row    (partial_last_row),
  .partial_wraps       (partial_wraps),
  .partial_from_bottom (partial_from_bottom)
);
`default_nettype wire

// file: testbench/fmwa_host_model.sv
`default_nettype none
module fmwa_host_model
  import fmwa_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               read_valid,
  input  wire logic [FMWA_RW-1:0] read_data,
  output logic                    cmd_valid,
  output logic [7:0]              cmd_code,
  output logic                    data_valid,
  output logic [FMWA_PW-1:0]      data_in,
  output logic                    read_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // host bus cycles
  // ****************************************************************
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'hFF;
    data_valid = 1'b0;
    data_in = '0;
    read_req = 1'b0;
  end
  // one word a cycle; calling again at once gives back-to-back words
  task automatic put(input logic c, input logic [FMWA_PW-1:0] v);
    @(posedge sys_clk);
    #1;
    cmd_valid = c;
    data_valid = !c;
    cmd_code = v[7:0];
    data_in = v;
  endtask
  // released lines show the inverse so a stale word cannot pass
  task automatic idle();
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    data_valid = 1'b0;
    cmd_code = ~cmd_code;
    data_in = ~data_in;
  endtask
  // strobe once and wait a bounded time for the word
  task automatic rd(output logic [FMWA_RW-1:0] d);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    data_valid = 1'b0;
    read_req = 1'b1;
    @(posedge sys_clk);
    #1;
    read_req = 1'b0;
    d = 'x;
    // the word stands for one cycle only, so look before each further edge
    for (int i = 0; i < 3; i++) begin
      if (read_valid === 1'b1) begin
        d = read_data;
        break;
      end
      @(posedge sys_clk);
      #1;
    end
  endtask
endmodule
`default_nettype wire

// file: testbench/fmwa_top_tb.sv
`default_nettype none
module fmwa_top_tb
  import fmwa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // bench
  // ****************************************************************
  logic sys_clk = 1'b0, rst = 1'b1, row_column_exchange = 1'b0, line_order_select = 1'b0;
  logic cmd_valid, data_valid, read_req, read_valid, partial_wraps, partial_from_bottom;
  logic transfer_busy;
  logic [7:0] cmd_code;
  logic [FMWA_PW-1:0] data_in;
  logic [FMWA_RW-1:0] read_data;
  logic [FMWA_AW-1:0] window_first_column, window_last_column, window_first_page;
  logic [FMWA_AW-1:0] window_last_page, partial_first_row, partial_last_row;
  int error_cnt = 0;
  int comparisons = 0;
  // partial rows kept within 1..1DF by the host
  logic [8:0] pf[3] = '{9'h110, 9'h007, 9'h001};
  logic [8:0] pl[3] = '{9'h020, 9'h007, 9'h1DF};
  always #4 sys_clk = ~sys_clk;
  // a 4x4 store keeps every window walk short
  fmwa_top #(.COLS(4), .PAGES(4)) fmwa_top_inst (
    .sys_clk             (sys_clk),
    .rst                 (rst),
    .cmd_valid           (cmd_valid),
    .cmd_code            (cmd_code),
    .data_valid          (data_valid),
    .data_in             (data_in),
    .read_req            (read_req),
    .row_column_exchange (row_column_exchange),
    .line_order_select   (line_order_select),
    .read_valid          (read_valid),
    .read_data           (read_data),
    .window_first_column (window_first_column),
    .window_last_column  (window_last_column),
    .window_first_page   (window_first_page),
    .window_last_page    (window_last_page),
    .partial_first_row   (partial_first_row),
    .partial_last_row    (partial_last_row),
    .partial_wraps       (partial_wraps),
    .partial_from_bottom (partial_from_bottom),
    .transfer_busy       (transfer_busy)
  );
  fmwa_host_model fmwa_host_model_inst (
    .sys_clk    (sys_clk),
    .read_valid (read_valid),
    .read_data  (read_data),
    .cmd_valid  (cmd_valid),
    .cmd_code   (cmd_code),
    .data_valid (data_valid),
    .data_in    (data_in),
    .read_req   (read_req)
  );
  function automatic logic [17:0] pv(int i);
    return 18'(18'h0F0F0 + 18'h01111 * i);
  endfunction
  function automatic logic [23:0] fmt(logic [17:0] p);
    return {p[17:12], 2'h0, p[11:6], 2'h0, p[5:0], 2'h0};
  endfunction
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // command with two 9-bit values, high bit first
  task automatic prm4(input logic [7:0] c, input logic [8:0] a, input logic [8:0] b);
    fmwa_host_model_inst.put(1'b1, {10'h0, c});
    fmwa_host_model_inst.put(1'b0, {17'h0, a[8]});
    fmwa_host_model_inst.put(1'b0, {10'h0, a[7:0]});
    fmwa_host_model_inst.put(1'b0, {17'h0, b[8]});
    fmwa_host_model_inst.put(1'b0, {10'h0, b[7:0]});
    fmwa_host_model_inst.idle();
  endtask
  task automatic wr(input int b, input int n);
    fmwa_host_model_inst.put(1'b1, {10'h0, FMWA_CMD_WRITE});
    for (int i = 0; i < n; i++) fmwa_host_model_inst.put(1'b0, pv(b + i));
    fmwa_host_model_inst.idle();
  endtask
  task automatic rdchk(input int a0, input int a1, input int a2, input int a3);
    logic [23:0] d;
    int e[4];
    e = '{a0, a1, a2, a3};
    fmwa_host_model_inst.put(1'b1, {10'h0, FMWA_CMD_READ});
    fmwa_host_model_inst.rd(d);
    chk("dummy", 24'h000000, d);
    for (int i = 0; i < 4; i++) begin
      fmwa_host_model_inst.rd(d);
      chk("pixel", fmt(pv(e[i])), d);
    end
  endtask
  task automatic rstvals();
    chk("first_col", 24'h0, window_first_column);
    chk("last_col", FMWA_COL_RST_LAST, window_last_column);
    chk("first_page", 24'h0, window_first_page);
    chk("last_page", FMWA_PAGE_RST_LAST, window_last_page);
    chk("part_first", FMWA_PART_RST_FIRST, partial_first_row);
    chk("part_last", FMWA_PART_RST_LAST, partial_last_row);
  endtask
  // window of columns 1..2 and pages 0..1, four pixels
  task automatic win();
    prm4(FMWA_CMD_COL, 9'h001, 9'h002);
    prm4(FMWA_CMD_PAGE, 9'h000, 9'h001);
  endtask
  // watchdog far beyond the 164 cycles of the run
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 rst = 1'b0;
    rstvals();
    win();
    prm4(FMWA_CMD_COL, 9'h003, 9'h001);
    prm4(FMWA_CMD_COL, 9'h000, 9'h004);
    chk("first_col", 24'h1, window_first_column);
    chk("last_col", 24'h2, window_last_column);
    chk("last_page", 24'h1, window_last_page);
    wr(0, 5);
    chk("busy", 24'h0, transfer_busy);
    rdchk(0, 1, 2, 3);
    row_column_exchange = 1'b1;
    wr(4, 4);
    rdchk(4, 5, 6, 7);
    row_column_exchange = 1'b0;
    rdchk(4, 6, 5, 7);
    wr(8, 2);
    chk("busy", 24'h1, transfer_busy);
    // an unknown command byte must still end the open write
    fmwa_host_model_inst.put(1'b1, 18'h00000);
    fmwa_host_model_inst.idle();
    chk("busy", 24'h0, transfer_busy);
    rdchk(8, 9, 5, 7);
    @(posedge sys_clk);
    #1 rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'b0;
    rstvals();
    win();
    rdchk(8, 9, 5, 7);
    for (int i = 0; i < 3; i++) begin
      line_order_select = ~line_order_select;
      prm4(FMWA_CMD_PART, pf[i], pl[i]);
      chk("part_first", pf[i], partial_first_row);
      chk("part_last", pl[i], partial_last_row);
      chk("wraps", (i == 0), partial_wraps);
      chk("bottom", line_order_select, partial_from_bottom);
    end
    summarize();
  end
endmodule
`default_nettype wire
